/* hw/cde_pkg.sv */
// package with the layout and address map of the component directory
package cde_pkg;

    // bus geometry
    localparam int unsigned ADDR_W         = 12;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned ENTRY_CNT      = 512;
    localparam int unsigned IDX_W          = 9;

    // printed offsets
    localparam logic [11:0] OFF_ENTRY_TWO  = 12'h008;
    localparam logic [11:0] OFF_ENTRY_LAST = 12'h7fc;
    localparam logic [11:0] OFF_DIR_END    = 12'h800;

    // entry field positions
    localparam int unsigned BASE_LSB       = 12;
    localparam int unsigned BASE_W         = 20;
    localparam int unsigned ZERO_HI_MSB    = 11;
    localparam int unsigned ZERO_HI_LSB    = 9;
    localparam int unsigned PD_MSB         = 8;
    localparam int unsigned PD_LSB         = 4;
    localparam int unsigned PD_W           = 5;
    localparam int unsigned ZERO_LO_BIT    = 3;
    localparam int unsigned PD_VALID_BIT   = 2;
    localparam int unsigned PRES_MSB       = 1;
    localparam int unsigned PRES_LSB       = 0;

    // presence codes
    typedef enum logic [1:0] {
        PRES_LAST     = 2'h0,
        PRES_RESERVED = 2'h1,
        PRES_SKIP     = 2'h2,
        PRES_HERE     = 2'h3
    } cde_pres_t;

    // one-word descriptor built from its fields
    typedef struct packed {
        logic [19:0] base_addr;
        logic [2:0]  zero_field_hi;
        logic [4:0]  pwr_domain_index;
        logic        zero_field_lo;
        logic        pwr_domain_index_valid;
        logic [1:0]  presence;
    } cde_entry_t;

    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

endpackage

/* hw/cde_rst_sync.sv */
// reset release synchroniser
`timescale 1ns/100ps
`default_nettype none
module cde_rst_sync (
    // clock and raw reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // released reset
    output logic      rst_n_o
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            sync_ff <= meta_ff;
        end
    end

    assign rst_n_o = sync_ff;
endmodule
`default_nettype wire

/* hw/cde_entry_fmt.sv */
// shapes one raw descriptor into a legal directory word
`timescale 1ns/100ps
`default_nettype none
module cde_entry_fmt (
    // raw configured descriptor
    input  wire logic [31:0] raw_i,
    // legal word
    output logic      [31:0] word_o
);
    cde_pkg::cde_entry_t raw;
    cde_pkg::cde_entry_t fmt;

    always_comb begin
        raw                        = cde_pkg::cde_entry_t'(raw_i);
        fmt                        = raw;
        fmt.zero_field_hi          = 3'h0;
        fmt.zero_field_lo          = 1'h0;
        // index is forced to zero unless flagged valid
        if (!raw.pwr_domain_index_valid) begin
            fmt.pwr_domain_index = 5'h00;
        end
        // reserved presence code is never emitted; treat as an absent slot
        // codes 0, 2 and 3 pass through unchanged
        if (raw.presence == cde_pkg::PRES_RESERVED) begin
            fmt.presence = cde_pkg::PRES_SKIP;
        end
        word_o = fmt;
    end
endmodule
`default_nettype wire

/* hw/cde_directory.sv */
// apb read-only directory of debug component descriptors
// Notes on behaviour
// - each entry describes one component and all entries share one field layout.
// - entry two reads at byte offset 0x008 as a 32-bit read-only word.
// - entry 511 reads at byte offset 0x7fc as a 32-bit read-only word.
// - bits 31..12 return the component base address fixed at configuration.
// - bits 11..9 and bit 3 read as zero, and writers must put zeros there.
// - the power-domain index spans 0 to 31, one per power-up request/ack pair.
// - bit 2 reads one only when the entry carries a valid power-domain index.
// - presence code 3 marks a present component and code 1 is never produced.
// - presence code 0 means no component and that this is the final entry.
// - presence code 2 means no component here while scanning goes on.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module cde_directory #(
    parameter int unsigned          ENTRY_CNT = cde_pkg::ENTRY_CNT,
    parameter logic [511:0][31:0]   ENTRIES   = '0
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic             pready_o,
    output logic      [31:0] prdata_o,
    output logic             pslverr_o
);
    logic        rst_n;
    logic        setup;
    logic        hit;
    logic [8:0]  idx;
    logic [31:0] raw_word;
    logic [31:0] legal_word;
    logic [31:0] nxt_rdata;
    logic        nxt_err;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    logic        pready_ff;

    cde_rst_sync u_rst (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .rst_n_o (rst_n)
    );

    // word index from a byte address
    function automatic logic [8:0] word_idx(input logic [11:0] a);
        word_idx = a[10:2];
    endfunction

    // entry 0 and 1 belong to other logic, so only 2..511 are decoded here
    function automatic logic in_dir(input logic [11:0] a);
        in_dir = (a >= cde_pkg::OFF_ENTRY_TWO) && (a < cde_pkg::OFF_DIR_END) && (a[1:0] == 2'h0);
    endfunction

    assign setup = psel_i && !penable_i;
    assign hit   = in_dir(paddr_i);
    assign idx   = word_idx(paddr_i);

    // configured table, one shared layout
    assign raw_word = ENTRIES[idx];

    cde_entry_fmt u_fmt (
        .raw_i  (raw_word),
        .word_o (legal_word)
    );

    // decode: reads of the directory return the word; writes are accepted and dropped
    always_comb begin
        nxt_rdata = cde_pkg::WORD_ZERO;
        nxt_err   = 1'b0;
        if (!hit) begin
            nxt_err = 1'b1;
        end else if (!pwrite_i) begin
            nxt_rdata = legal_word;
        end
    end

    // no wait state: answer registered in setup, ready in the first access cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
            pready_ff  <= 1'b0;
        end else begin
            pready_ff <= setup;
            if (setup) begin
                prdata_ff  <= nxt_rdata;
                pslverr_ff <= nxt_err;
            end
        end
    end

    assign pready_o  = pready_ff && psel_i && penable_i;
    assign prdata_o  = prdata_ff;
    assign pslverr_o = pslverr_ff && pready_o;

    // pwdata and pstrb are never stored: the directory is fixed
    logic unused_w;
    assign unused_w = ^{pwdata_i, pstrb_i};

    cde_pkg::cde_entry_t rd;
    assign rd = cde_pkg::cde_entry_t'(prdata_o);

    entry_zero_a:  assert property (@(posedge clk_i) disable iff (!rst_n)
        pready_o |-> rd.zero_field_hi == 3'h0 && !rd.zero_field_lo)
        else $error("zero field not zero");
    pd_gate_a:     assert property (@(posedge clk_i) disable iff (!rst_n)
        (pready_o && !rd.pwr_domain_index_valid) |-> rd.pwr_domain_index == 5'h00)
        else $error("domain index without valid flag");
    no_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        pready_o |-> rd.presence != cde_pkg::PRES_RESERVED)
        else $error("reserved presence code");
    read_data_a:   assert property (@(posedge clk_i) disable iff (!rst_n)
        (setup && hit && !pwrite_i) |=> penable_i |-> prdata_o == $past(legal_word))
        else $error("read data mismatch");
    write_zero_a:  assert property (@(posedge clk_i) disable iff (!rst_n)
        (pready_o && pwrite_i) |-> prdata_o == 32'h0000_0000)
        else $error("write returned data");
    unmapped_a:    assert property (@(posedge clk_i) disable iff (!rst_n)
        (setup && !hit) |=> (penable_i && psel_i) |-> pslverr_o)
        else $error("unmapped address not refused");
    ready_lat_a:   assert property (@(posedge clk_i) disable iff (!rst_n)
        setup |=> (psel_i && penable_i) |-> pready_o)
        else $error("ready not one cycle after setup");
    base_addr_a:   assert property (@(posedge clk_i) disable iff (!rst_n)
        (setup && hit && !pwrite_i) |=> penable_i |->
            rd.base_addr == $past(raw_word[31:12]))
        else $error("base address mismatch");
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking apb bench for the component directory
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // raw descriptors: a pattern plus two hand-picked corner words
    function automatic logic [511:0][31:0] mk();
        logic [511:0][31:0] e;
        for (int i = 0; i < 512; i++) begin
            e[i] = (i * 32'h0123_4567) ^ 32'h5a5a_5a5a;
        end
        e[2]   = 32'habcd_fe59;
        e[511] = 32'h1234_51f7;
        return e;
    endfunction
    localparam logic [511:0][31:0] ENT = mk();

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [31:0] rnd = 32'h28e3c4fa;
    logic [32:0] q[$];
    int          bad_count = 0;
    int          samples_checked = 0;

    always #4 clk = ~clk;

    cde_directory #(.ENTRY_CNT(512), .ENTRIES(ENT)) DUT (
        .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr));

    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    // unmapped or unaligned places answer with an error and zero data
    function automatic logic [32:0] ex(input logic [11:0] a, input logic wr);
        logic [31:0] r;
        r = ENT[a[10:2]];
        if (a < cde_pkg::OFF_ENTRY_TWO || a >= cde_pkg::OFF_DIR_END || a[1:0] != 2'h0) return {1'b1, 32'h0};
        if (wr) return 33'h0;
        return {1'b0, r[31:12], 3'h0, r[2] ? r[8:4] : 5'h0, 1'b0, r[2], (r[1:0] == 2'h1) ? 2'h2 : r[1:0]};
    endfunction

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_flag(input string n, input logic e, input logic g);
        samples_checked++;
        if (e !== g) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask

    // psel stays up at the end so a next setup may follow at once
    task automatic apb(input logic wr, input logic [11:0] a);
        int n;
        q.push_back(ex(a, wr));
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= xs();
        pstrb <= 4'(xs());
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // pready is sampled at the rising edge that completes the access
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        penable <= 1'b0;
    endtask

    // read data and response are taken at the edge where pready is seen high
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            if (q.size() == 0) chk_flag("queue", 1'b1, 1'b0);
            else begin
                chk_word("prdata", q[0][31:0], prdata);
                chk_flag("pslverr", q[0][32], pslverr);
                void'(q.pop_front());
            end
        end
    end

    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 2; i < 512; i++) apb(1'b0, 12'(i * 4));
        apb(1'b0, 12'h000);
        apb(1'b0, 12'h004);
        apb(1'b0, 12'h800);
        apb(1'b1, cde_pkg::OFF_ENTRY_TWO);
        apb(1'b0, cde_pkg::OFF_ENTRY_TWO);
        apb(1'b1, cde_pkg::OFF_ENTRY_LAST);
        apb(1'b0, cde_pkg::OFF_ENTRY_LAST);
        for (int i = 0; i < 300; i++) apb(xs() % 2 == 0, 12'(xs() % 12'hffc));
        psel <= 1'b0;
        repeat (3) @(posedge clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
